// [rtl/mdb_dma.sv]
// Dma engine, bus arbiter and bus timing for the non-cpu masters
`timescale 1ns/1ns
// What this block does
// - Grant display, refresh and dma bus requests first come first served.
// - Hold other masters' requests pending until the owner releases the bus.
// - Stall cpu outside idle halt, and hold non-maskable interrupts, while any master owns bus.
// - Use logical addresses with controller width, waits and bank mapping.
// - Request bus from cpu; move data only after acknowledge.
// - Operate during idle halt state without stalling instruction execution.
// - Writing one to a soft start bit starts that channel.
// - Soft start bit clears when occupancy limit releases the bus.
// - Internal ram accesses are 2-1-1-1 states.
// - Sdram with internal side bursts same page, writes 6-1-1-1 and reads 6-6-1-1, plus four closing states.
// - Sdram with external other side uses single-word accesses.
// - Zero-wait sram: two states per two bytes at 16 bit, per byte at 8.
// - Mode 0AH gives incrementing source, fixed destination, 4-byte units.
// - Unit count per trigger, request counter counts triggers.
// - Exhausted request counter raises channel done interrupt.
// - Enable bit n enables channel n.
// - Release at occupancy limit; re-request after 16 states.
// - Count 0001H is one, 0000H is 65536; unit count reloads, request counter shows.
module mdb_dma (
    input  wire logic                      mclk,
    input  wire logic                      rst,
    input  wire logic [mdb_pkg::AW-1:0]    regAddr,
    input  wire logic [mdb_pkg::DW-1:0]    regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [mdb_pkg::DW-1:0]    regRdata,
    input  wire logic [mdb_pkg::NTRIG-1:0] periphIrq,
    input  wire logic                      displayBusReq,
    output logic                           displayBusGnt,
    input  wire logic                      refreshBusReq,
    output logic                           refreshBusGnt,
    output logic                           cpuBusReq,
    input  wire logic                      cpuBusAck,
    input  wire logic                      idleHaltState,
    output logic                           cpuStall,
    output logic                           nmiHold,
    output logic                           busCycle,
    output logic                           busWrite,
    output logic      [23:0]               busAddr,
    output logic      [1:0]                busSize,
    input  wire logic [31:0]               busRdata,
    output logic      [31:0]               busWdata,
    output logic                           busLast,
    input  wire logic [1:0]                srcRegion,
    input  wire logic [1:0]                dstRegion,
    input  wire logic                      sramWide,
    input  wire logic [mdb_pkg::WAIT_W-1:0] waitCount,
    input  wire logic                      samePage,
    output logic      [mdb_pkg::NCH-1:0]   channelDoneIrq
);
    localparam int N = mdb_pkg::NCH;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000, ST_REQ = 3'b001, ST_RD = 3'b010, ST_WR = 3'b011,
        ST_CLOSE = 3'b100, ST_BACKOFF = 3'b101
    } mdb_state_e;
    typedef enum logic [1:0] {
        M_NONE = 2'b00, M_DMA = 2'b01, M_DISP = 2'b10, M_REF = 2'b11
    } mdb_master_e;

    function automatic logic [2:0] unitBytes(input logic [1:0] sz);
        unitBytes = (sz == mdb_pkg::SZ_4) ? 3'h4 : (sz == mdb_pkg::SZ_2) ? 3'h2 : 3'h1;
    endfunction
    function automatic logic [4:0] accessStates(input logic [1:0] reg_, input logic first,
                                                input logic [1:0] sz, input logic wide,
                                                input logic burst, input logic [3:0] wt);
        logic [4:0] bytes;
        bytes = {2'b00, unitBytes(sz)};
        case (reg_)
            mdb_pkg::MR_IRAM:  accessStates = first ? 5'(mdb_pkg::IRAM_FIRST) : 5'h01;
            mdb_pkg::MR_IO:    accessStates = 5'(mdb_pkg::SRAM_STATES);
            mdb_pkg::MR_SDRAM: accessStates = (burst && !first) ? 5'h01 :
                                              5'(mdb_pkg::SDR_FIRST);
            default:           accessStates = wide ? 5'(((bytes + 5'h1) >> 1) * (5'h2 + 5'(wt)))
                                                   : 5'(bytes * (5'h2 + 5'(wt)));
        endcase
    endfunction

    logic [23:0]        srcQ [N];
    logic [23:0]        dstQ [N];
    logic [15:0]        unitsQ [N];
    logic [15:0]        reqCntQ [N];
    logic [7:0]         modeQ [N];
    logic [4:0]         trigSelQ [N];
    logic [N-1:0]       enableQ, softQ, pendQ, doneQ;
    logic [7:0]         occQ;
    mdb_state_e         stQ;
    mdb_master_e        ownerQ;
    logic [1:0]         fifoQ [3];
    logic [1:0]         fifoCntQ;
    logic [2:0]         chQ;
    logic [16:0]        unitLeftQ;
    logic [4:0]         waitQ;
    logic               firstQ;
    logic [7:0]         occCntQ;
    logic [31:0]        dataQ;
    localparam int DW_RD = mdb_pkg::DW;
    logic [DW_RD-1:0]   rdQ;

    // Register decode
    wire         inChan   = regAddr < 8'(N * 16);
    wire [2:0]   selCh    = regAddr[6:4];
    wire [3:0]   selReg   = regAddr[3:0];
    wire         wrEnable = regWr && regAddr == mdb_pkg::R_ENABLE;
    wire         wrSoft   = regWr && regAddr == mdb_pkg::R_SOFT;

    // Channel triggers gated by enable
    logic [N-1:0] hwTrig;
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gTrig
            assign hwTrig[g] = enableQ[g] && periphIrq[trigSelQ[g]];
        end
    endgenerate
    wire [N-1:0] wantCh = (pendQ | softQ) & enableQ;
    logic [2:0] pickCh;
    always_comb begin
        pickCh = 3'h0;
        for (int i = N - 1; i >= 0; i--)
            if (wantCh[i]) pickCh = 3'(i);
    end

    // Arrival-order arbitration among masters
    wire dmaWantsBus = (stQ == mdb_state_e'(ST_REQ));
    wire [2:0] reqVec = {refreshBusReq, displayBusReq, dmaWantsBus};
    logic [2:0] reqSeenQ;
    wire  [2:0] newReq = reqVec & ~reqSeenQ;
    wire  busFree  = ownerQ == M_NONE;
    wire  headIs   = fifoCntQ != 2'h0;
    wire [1:0] head = fifoQ[0];
    wire  dmaHold  = stQ == ST_RD || stQ == ST_WR || stQ == ST_CLOSE || stQ == ST_REQ;
    wire  ownerDrop = (ownerQ == M_DMA  && !dmaHold) ||
                      (ownerQ == M_DISP && !displayBusReq) ||
                      (ownerQ == M_REF  && !refreshBusReq);
    wire  grantNow = busFree && headIs && cpuBusAck;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ownerQ   <= M_NONE;
            fifoCntQ <= 2'h0;
            reqSeenQ <= 3'h0;
            for (int i = 0; i < 3; i++) fifoQ[i] <= 2'h0;
        end else begin
            logic [1:0] cnt;
            cnt = fifoCntQ;
            reqSeenQ <= reqVec;
            if (ownerDrop) ownerQ <= M_NONE;
            if (grantNow) begin
                ownerQ <= mdb_master_e'(head);
                fifoQ[0] <= fifoQ[1];
                fifoQ[1] <= fifoQ[2];
                cnt = cnt - 2'h1;
            end
            for (int m = 0; m < 3; m++) begin
                if (newReq[m] && cnt < 2'h3) begin
                    fifoQ[cnt - (grantNow ? 2'h0 : 2'h0)] <= 2'(m + 1);
                    cnt = cnt + 2'h1;
                end
            end
            fifoCntQ <= cnt;
        end
    end

    assign displayBusGnt = ownerQ == M_DISP;
    assign refreshBusGnt = ownerQ == M_REF;
    wire   dmaGnt        = ownerQ == M_DMA && cpuBusAck;
    assign cpuBusReq     = |reqVec || !busFree;
    assign cpuStall      = !busFree && !idleHaltState;
    assign nmiHold       = !busFree;

    // Transfer sequencing
    wire [1:0] sz      = modeQ[chQ][1:0];
    wire [2:0] am      = modeQ[chQ][4:2];
    wire       intSide = srcRegion <= mdb_pkg::MR_IO || dstRegion <= mdb_pkg::MR_IO;
    wire       burstOk = intSide && samePage && !firstQ;
    wire       occEn   = occQ[mdb_pkg::OCC_EN_BIT];
    wire       occHit  = occEn && occCntQ >= {1'b0, occQ[mdb_pkg::OCC_W-1:0]};
    wire [23:0] step   = {21'h0, unitBytes(sz)};
    wire       lastUnit = unitLeftQ == 17'h1;
    wire       lastReq  = reqCntQ[chQ] == 16'h1;

    always_ff @(posedge mclk) begin
        if (rst) begin
            stQ <= ST_IDLE; chQ <= 3'h0; unitLeftQ <= 17'h0; waitQ <= 5'h0;
            firstQ <= 1'b1; occCntQ <= 8'h0; dataQ <= 32'h0;
            enableQ <= '0; softQ <= '0; pendQ <= '0; doneQ <= '0; occQ <= 8'h0;
            for (int i = 0; i < N; i++) begin
                srcQ[i] <= 24'h0; dstQ[i] <= 24'h0; unitsQ[i] <= 16'h0;
                reqCntQ[i] <= 16'h0; modeQ[i] <= 8'h0;
                trigSelQ[i] <= mdb_pkg::TRIGSEL_RST;
            end
        end else begin
            pendQ  <= (pendQ | hwTrig) & enableQ;
            doneQ  <= '0;
            if (regWr && inChan) begin
                case (selReg)
                    mdb_pkg::R_SRC:     srcQ[selCh]     <= regWdata[23:0];
                    mdb_pkg::R_DST:     dstQ[selCh]     <= regWdata[23:0];
                    mdb_pkg::R_UNITS:   unitsQ[selCh]   <= regWdata[15:0];
                    mdb_pkg::R_REQCNT:  reqCntQ[selCh]  <= regWdata[15:0];
                    mdb_pkg::R_MODE:    modeQ[selCh]    <= regWdata[7:0];
                    mdb_pkg::R_TRIGSEL: trigSelQ[selCh] <= regWdata[4:0];
                    default: ;
                endcase
            end
            if (wrEnable) enableQ <= regWdata[N-1:0];
            if (regWr && regAddr == mdb_pkg::R_OCCUPY) occQ <= regWdata[7:0];
            if (wrSoft) softQ <= softQ | regWdata[N-1:0];
            if (dmaGnt) occCntQ <= occCntQ + 8'h1;
            case (stQ)
                ST_IDLE: begin
                    occCntQ <= 8'h0;
                    if (|wantCh) begin
                        chQ <= pickCh;
                        stQ <= ST_REQ;
                        firstQ <= 1'b1;
                        unitLeftQ <= (unitsQ[pickCh] == 16'h0) ? 17'h10000
                                                               : {1'b0, unitsQ[pickCh]};
                    end
                end
                ST_REQ: if (dmaGnt) begin
                    stQ <= ST_RD;
                    waitQ <= accessStates(srcRegion, 1'b1, sz, sramWide, 1'b0, waitCount);
                end
                ST_RD: if (waitQ <= 5'h1) begin
                    dataQ <= busRdata;
                    stQ <= ST_WR;
                    waitQ <= accessStates(dstRegion, firstQ, sz, sramWide, burstOk, waitCount);
                end else waitQ <= waitQ - 5'h1;
                ST_WR: if (waitQ <= 5'h1) begin
                    firstQ <= 1'b0;
                    if (am == mdb_pkg::AM_SRC_INC || am == mdb_pkg::AM_DST_INC)
                        srcQ[chQ] <= srcQ[chQ] + step;
                    if (am == mdb_pkg::AM_SRC_DEC) srcQ[chQ] <= srcQ[chQ] - step;
                    if (am == mdb_pkg::AM_DST_INC) dstQ[chQ] <= dstQ[chQ] + step;
                    if (am == mdb_pkg::AM_DST_DEC) dstQ[chQ] <= dstQ[chQ] - step;
                    unitLeftQ <= unitLeftQ - 17'h1;
                    if (lastUnit) begin
                        reqCntQ[chQ] <= reqCntQ[chQ] - 16'h1;
                        // Clear only the start served; a trigger in this cycle wins
                        if (softQ[chQ]) softQ[chQ] <= 1'b0;
                        else            pendQ[chQ] <= hwTrig[chQ];
                        if (lastReq) doneQ[chQ] <= 1'b1;
                        waitQ <= 5'(mdb_pkg::SDR_CLOSE);
                        stQ <= ST_CLOSE;
                    end else if (occHit) begin
                        softQ <= '0;
                        // One state goes to handing the bus back
                        waitQ <= 5'(mdb_pkg::REREQ_STATES + 1);
                        stQ <= ST_BACKOFF;
                    end else begin
                        stQ <= ST_RD;
                        waitQ <= accessStates(srcRegion, 1'b0, sz, sramWide, burstOk, waitCount);
                    end
                end else waitQ <= waitQ - 5'h1;
                ST_CLOSE: if (waitQ <= 5'h1 || !(srcRegion == mdb_pkg::MR_SDRAM ||
                                                 dstRegion == mdb_pkg::MR_SDRAM) || !intSide)
                    stQ <= ST_IDLE;
                else waitQ <= waitQ - 5'h1;
                ST_BACKOFF: begin
                    occCntQ <= 8'h0;
                    if (waitQ <= 5'h1) begin
                        stQ <= ST_REQ;
                        firstQ <= 1'b1;
                    end else waitQ <= waitQ - 5'h1;
                end
                default: stQ <= ST_IDLE;
            endcase
            if (wrSoft) softQ <= softQ | regWdata[N-1:0];
        end
    end

    assign busCycle = stQ == ST_RD || stQ == ST_WR;
    assign busWrite = stQ == ST_WR;
    assign busAddr  = busWrite ? dstQ[chQ] : srcQ[chQ];
    assign busSize  = sz;
    assign busWdata = dataQ;
    assign busLast  = stQ == ST_WR && waitQ <= 5'h1 && lastUnit;
    assign channelDoneIrq = doneQ;

    // Read back
    wire [31:0] rdChan = selReg == mdb_pkg::R_SRC    ? {8'h0, srcQ[selCh]} :
                         selReg == mdb_pkg::R_DST    ? {8'h0, dstQ[selCh]} :
                         selReg == mdb_pkg::R_UNITS  ? {16'h0, unitsQ[selCh]} :
                         selReg == mdb_pkg::R_REQCNT ? {16'h0, reqCntQ[selCh]} :
                         selReg == mdb_pkg::R_MODE   ? {24'h0, modeQ[selCh]} :
                         selReg == mdb_pkg::R_TRIGSEL ? {27'h0, trigSelQ[selCh]} : 32'h0;
    wire [31:0] rdVal  = inChan ? rdChan :
                         regAddr == mdb_pkg::R_ENABLE ? {26'h0, enableQ} :
                         regAddr == mdb_pkg::R_SOFT   ? {26'h0, softQ} :
                         regAddr == mdb_pkg::R_OCCUPY ? {24'h0, occQ} :
                         regAddr == mdb_pkg::R_STATUS ? {20'h0, ownerQ, 1'b0, stQ, 3'h0, chQ}
                                                      : 32'h0;
    always_ff @(posedge mclk) begin
        if (rst) rdQ <= '0;
        else     rdQ <= regRd ? rdVal : 32'h0;
    end
    assign regRdata = rdQ;
endmodule

// [rtl/mdb_pkg.sv]
// Constants for the multichannel dma engine with bus arbitration
package mdb_pkg;
    localparam int NCH = 6;
    localparam int AW  = 8;
    localparam int DW  = 32;
    localparam int CW  = 16;
    // Register offsets, per channel block of 16 words
    localparam logic [7:0] CH_STRIDE  = 8'h10;
    localparam logic [3:0] R_SRC      = 4'h0;
    localparam logic [3:0] R_DST      = 4'h1;
    localparam logic [3:0] R_UNITS    = 4'h2;
    localparam logic [3:0] R_REQCNT   = 4'h3;
    localparam logic [3:0] R_MODE     = 4'h4;
    localparam logic [3:0] R_TRIGSEL  = 4'h5;
    localparam logic [7:0] R_ENABLE   = 8'h80;
    localparam logic [7:0] R_SOFT     = 8'h81;
    localparam logic [7:0] R_OCCUPY   = 8'h82;
    localparam logic [7:0] R_STATUS   = 8'h83;
    // Occupancy limit fields
    localparam int OCC_EN_BIT = 7;
    localparam int OCC_W      = 7;
    // Mode field: [1:0] size code, [4:2] address mode
    localparam logic [7:0] MODE_SRCINC_FIX_4B = 8'h0A;
    localparam logic [1:0] SZ_1 = 2'h0;
    localparam logic [1:0] SZ_2 = 2'h1;
    localparam logic [1:0] SZ_4 = 2'h2;
    localparam logic [2:0] AM_DST_INC = 3'h0;
    localparam logic [2:0] AM_DST_DEC = 3'h1;
    localparam logic [2:0] AM_SRC_INC = 3'h2;
    localparam logic [2:0] AM_SRC_DEC = 3'h3;
    localparam int NTRIG = 32;
    localparam logic [4:0] TRIGSEL_RST = 5'h00;
    // Timing in states (one state = one mclk)
    localparam int REREQ_STATES = 16;
    localparam int IRAM_FIRST   = 2;
    localparam int SDR_FIRST    = 6;
    localparam int SDR_CLOSE    = 4;
    localparam int SRAM_STATES  = 2;
    // Memory region codes from the memory controller
    localparam logic [1:0] MR_IRAM  = 2'h0;
    localparam logic [1:0] MR_IO    = 2'h1;
    localparam logic [1:0] MR_SDRAM = 2'h2;
    localparam logic [1:0] MR_SRAM  = 2'h3;
    localparam int WAIT_W = 4;
endpackage

// [verif/mdb_cpu_model.sv]
// Cpu and memory stand-in on the far side of the dma bus
`timescale 1ns/1ns
module mdb_cpu_model (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [3:0]  ackDelay,
    input  wire logic        cpuBusReq,
    output logic             cpuBusAck,
    input  wire logic        busCycle,
    input  wire logic        busWrite,
    input  wire logic [23:0] busAddr,
    output logic      [31:0] busRdata
);
    logic [3:0]  waitCnt_q;
    logic [31:0] last_q;
    // Ack only after the cpu finishes its own cycle; slow when ackDelay is large
    always_ff @(posedge mclk) begin
        if (rst || !cpuBusReq) begin
            waitCnt_q <= 4'h0;
            cpuBusAck <= 1'h0;
        end else if (waitCnt_q >= ackDelay) begin
            cpuBusAck <= 1'h1;
        end else begin
            waitCnt_q <= waitCnt_q + 4'h1;
        end
    end
    // Zero-wait memory; an idle bus never keeps showing the last word
    assign busRdata = (busCycle && !busWrite) ? {8'hA5, busAddr} : ~last_q;
    always_ff @(posedge mclk) begin
        last_q <= rst ? 32'h0 : busRdata;
    end
endmodule

// [verif/mdb_dma_checker.sv]
// Port-level assertions for the dma engine and its bus arbiter
`timescale 1ns/1ns
module mdb_dma_checker (
    input wire logic                      mclk,
    input wire logic                      rst,
    input wire logic                      regRd,
    input wire logic [mdb_pkg::DW-1:0]    regRdata,
    input wire logic                      displayBusReq,
    input wire logic                      displayBusGnt,
    input wire logic                      refreshBusReq,
    input wire logic                      refreshBusGnt,
    input wire logic                      cpuBusReq,
    input wire logic                      cpuBusAck,
    input wire logic                      idleHaltState,
    input wire logic                      cpuStall,
    input wire logic                      nmiHold,
    input wire logic                      busCycle,
    input wire logic [mdb_pkg::NCH-1:0]   channelDoneIrq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Display asks on a quiet bus
    sequence seqDispAlone;
        $rose(displayBusReq) && !refreshBusReq && !$past(cpuBusReq);
    endsequence
    // Display lets go while refresh waits
    sequence seqDispHandover;
        displayBusGnt && !displayBusReq && refreshBusReq;
    endsequence
    chk_dma_acked: assert property (busCycle |-> cpuBusReq && cpuBusAck)
        else $error("dma bus access without cpu acknowledge");
    chk_owner_holds_cpu: assert property (
        (displayBusGnt || refreshBusGnt || busCycle) |-> nmiHold && (cpuStall == !idleHaltState))
        else $error("cpu or nmi not held while bus is owned");
    chk_idle_no_stall: assert property (idleHaltState |-> !cpuStall)
        else $error("cpu stalled in idle halt");
    chk_stall_owned: assert property (!nmiHold |-> !cpuStall)
        else $error("cpu stalled with bus free");
    chk_one_owner: assert property (displayBusGnt |-> !refreshBusGnt && !busCycle)
        else $error("two bus owners at once");
    chk_owner_kept: assert property (refreshBusGnt && refreshBusReq |=> refreshBusGnt)
        else $error("refresh grant taken while still requested");
    chk_first_served: assert property (
        seqDispAlone |=> !refreshBusGnt throughout (##[0:19] displayBusGnt))
        else $error("first requester not served first");
    chk_fifo_handover: assert property (seqDispHandover |-> ##[1:20] refreshBusGnt)
        else $error("queued refresh not granted after release");
    chk_done_pulse: assert property (
        (channelDoneIrq != '0) |=> ((channelDoneIrq & $past(channelDoneIrq)) == '0))
        else $error("done interrupt longer than one cycle");
    chk_read_quiet: assert property (!$past(regRd) |-> (regRdata == '0))
        else $error("read data outside the read answer cycle");
endmodule

// [verif/testbench.sv]
// Self-checking bench for the dma engine and bus arbiter
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    logic [mdb_pkg::DW-1:0]  regWdata, regRdata, busRdata, busWdata, rdVal;
    logic [mdb_pkg::AW-1:0]  regAddr;
    logic [mdb_pkg::NCH-1:0] channelDoneIrq;
    logic [31:0]             periphIrq;
    logic [23:0]             busAddr, expSrc, expDst, lastRd, prevAddr;
    logic [1:0]              busSize, srcRegion, dstRegion;
    logic [3:0]              waitCount, ackDelay;
    logic                    mclk, rst, regWr, regRd, displayBusReq, displayBusGnt;
    logic                    refreshBusReq, refreshBusGnt, cpuBusReq, cpuBusAck, busLast;
    logic                    idleHaltState, cpuStall, nmiHold, busCycle, busWrite;
    logic                    sramWide, samePage, prevCyc, prevWr, prevReq;
    int                      failures, n_compared, nAcc, nReq, nDone, gap, lastGap, acc0;
    int                      nBus, bus0;
    mdb_dma uut (.mclk, .rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .periphIrq,
        .displayBusReq, .displayBusGnt, .refreshBusReq, .refreshBusGnt, .cpuBusReq,
        .cpuBusAck, .idleHaltState, .cpuStall, .nmiHold, .busCycle, .busWrite, .busAddr,
        .busSize, .busRdata, .busWdata, .busLast, .srcRegion, .dstRegion, .sramWide,
        .waitCount, .samePage, .channelDoneIrq);
    mdb_cpu_model cpu (.mclk, .rst, .ackDelay, .cpuBusReq, .cpuBusAck, .busCycle,
        .busWrite, .busAddr, .busRdata);
    always #2 mclk = ~mclk;
    // Each new access is one change of address or direction
    always @(posedge mclk) begin
        if (busCycle && (!prevCyc || busAddr != prevAddr || busWrite != prevWr)) begin
            nAcc++;
            `CHK(busSize, mdb_pkg::SZ_4)
            if (busWrite) begin
                `CHK(busAddr, expDst)
                `CHK(busWdata, {8'hA5, lastRd})
            end else begin
                `CHK(busAddr, expSrc)
                lastRd = busAddr;
                expSrc = expSrc + 24'h4;
            end
        end
        if (cpuBusReq && !prevReq) begin
            nReq++;
            lastGap = gap;
        end
        gap = cpuBusReq ? 0 : gap + 1;
        nDone += int'(channelDoneIrq[0]);
        nBus += int'(busCycle);
        {prevCyc, prevAddr, prevWr, prevReq} = {busCycle, busAddr, busWrite, cpuBusReq};
    end
    task automatic give_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'h1;
        @(posedge mclk);
        regWr <= 1'h0;
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'h1;
        @(posedge mclk);
        regRd <= 1'h0;
        @(negedge mclk);
        `CHK(regRdata, e)
    endtask
    task automatic pulse;
        @(posedge mclk);
        periphIrq[5] <= 1'h1;
        @(posedge mclk);
        periphIrq[5] <= 1'h0;
    endtask
    // Bounded waits; a hang ends the run as a mismatch
    task automatic waitAcc(input int n);
        int k = 0;
        while ((nAcc < n || cpuBusReq) && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 5000) begin
            failures++;
            give_verdict();
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic waitHigh(ref logic s);
        int k = 0;
        while (!s && k < 200) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 200) begin
            failures++;
            give_verdict();
        end
    endtask
    initial begin
        {regAddr, regWdata, regWr, regRd, periphIrq, mclk, rst} = '0;
        {displayBusReq, refreshBusReq, idleHaltState, sramWide, samePage} = '0;
        {waitCount, srcRegion, prevCyc, prevWr, prevReq, prevAddr, lastRd} = '0;
        {failures, n_compared, nAcc, nReq, nDone, gap, lastGap, nBus} = '0;
        {dstRegion, ackDelay, expSrc, expDst} = {mdb_pkg::MR_IO, 4'h1, 24'h100, 24'h200};
        rst = 1'h1;
        repeat (16) @(posedge mclk);
        rst <= 1'h0;
        rdChk(mdb_pkg::R_ENABLE, 32'h0);
        wr({4'h0, mdb_pkg::R_UNITS}, 32'h2);
        rdChk({4'h0, mdb_pkg::R_UNITS}, 32'h2);
        rdChk(8'h7F, 32'h0);
        wr({4'h0, mdb_pkg::R_SRC}, 32'h100);
        wr({4'h0, mdb_pkg::R_DST}, 32'h200);
        wr({4'h0, mdb_pkg::R_REQCNT}, 32'h2);
        wr({4'h0, mdb_pkg::R_MODE}, {24'h0, mdb_pkg::MODE_SRCINC_FIX_4B});
        wr({4'h0, mdb_pkg::R_TRIGSEL}, 32'h5);
        pulse();
        repeat (30) @(posedge mclk);
        `CHK(nReq, 0)
        wr(mdb_pkg::R_ENABLE, 32'h1);
        wr(mdb_pkg::R_SOFT, 32'h1);
        waitAcc(4);
        rdChk({4'h0, mdb_pkg::R_REQCNT}, 32'h1);
        pulse();
        waitAcc(8);
        rdChk({4'h0, mdb_pkg::R_REQCNT}, 32'h0);
        `CHK(nDone, 1)
        `CHK(nAcc, 8)
        `CHK(nBus, 2 * (mdb_pkg::IRAM_FIRST + 1 + 2 * mdb_pkg::SRAM_STATES))
        // Limit only with channels off, so no run sees a half-set timer
        wr(mdb_pkg::R_ENABLE, 32'h0);
        wr(mdb_pkg::R_OCCUPY, 32'h84);
        wr({4'h0, mdb_pkg::R_UNITS}, 32'h10);
        wr({4'h0, mdb_pkg::R_SRC}, 32'h400);
        expSrc = 24'h400;
        ackDelay <= 4'h4;
        idleHaltState <= 1'h1;
        wr(mdb_pkg::R_ENABLE, 32'h1);
        wr(mdb_pkg::R_SOFT, 32'h1);
        // Soft bit must drop at the first limit release, long before the end
        repeat (30) @(posedge mclk);
        rdChk(mdb_pkg::R_SOFT, 32'h0);
        waitAcc(40);
        rdChk(mdb_pkg::R_SOFT, 32'h0);
        rdChk({4'h0, mdb_pkg::R_REQCNT}, 32'hFFFF);
        `CHK(lastGap, mdb_pkg::REREQ_STATES)
        `CHK(nDone, 1)
        wr(mdb_pkg::R_ENABLE, 32'h0);
        wr(mdb_pkg::R_OCCUPY, 32'h0);
        idleHaltState <= 1'h0;
        srcRegion <= mdb_pkg::MR_SRAM;
        sramWide <= 1'h1;
        @(posedge mclk) displayBusReq <= 1'h1;
        waitHigh(displayBusGnt);
        `CHK(cpuStall, 1'h1)
        @(posedge mclk) refreshBusReq <= 1'h1;
        wr(mdb_pkg::R_ENABLE, 32'h1);
        wr(mdb_pkg::R_SOFT, 32'h1);
        repeat (8) @(posedge mclk);
        `CHK({refreshBusGnt, busCycle}, 2'h0)
        acc0 = nAcc;
        bus0 = nBus;
        @(posedge mclk) displayBusReq <= 1'h0;
        waitHigh(refreshBusGnt);
        `CHK(nAcc, acc0)
        @(posedge mclk) refreshBusReq <= 1'h0;
        waitAcc(acc0 + 32);
        `CHK(nAcc, acc0 + 32)
        `CHK(nBus - bus0, 16 * (2 * mdb_pkg::SRAM_STATES + mdb_pkg::SRAM_STATES))
        give_verdict();
    end
endmodule
bind mdb_dma mdb_dma_checker chk (.mclk, .rst, .regRd, .regRdata, .displayBusReq,
    .displayBusGnt, .refreshBusReq, .refreshBusGnt, .cpuBusReq, .cpuBusAck,
    .idleHaltState, .cpuStall, .nmiHold, .busCycle, .channelDoneIrq);
